// ===== design/fspc_pkg.sv
// Package for the framed serial port: register map, field positions, reset values.
// Assumes a Wishbone classic slave with 32-bit data, registers in the low 16 bits.
package fspc_pkg;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h4;
   localparam logic [3:0] ADDR_CTRL2 = 4'h8;
   localparam logic [3:0] ADDR_DATA = 4'hC;
   // Status and control word
   localparam int ST_PORT_ON = 15;
   localparam int ST_IDLE_HALT = 13;
   localparam int ST_RX_OVF = 6;
   localparam int ST_TX_FULL = 1;
   localparam int ST_RX_FULL = 0;
   // Control word one
   localparam int C1_CLK_OFF = 12;
   localparam int C1_SDO_OFF = 11;
   localparam int C1_WIDE = 10;
   localparam int C1_SMP = 9;
   localparam int C1_OUT_EDGE = 8;
   localparam int C1_SEL_EN = 7;
   localparam int C1_CKP = 6;
   localparam int C1_MASTER = 5;
   localparam int C1_SEC_LO = 2;
   localparam int C1_PRI_LO = 0;
   localparam logic [15:0] C1_MASK = 16'h1FFF;
   // Control word two
   localparam int C2_FRM_EN = 15;
   localparam int C2_FRM_DIR = 14;
   localparam int C2_FRM_POL = 13;
   localparam int C2_FRM_DLY = 1;
   localparam logic [15:0] C2_MASK = 16'hE002;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [4:0] BITS_BYTE = 5'h08;
   localparam logic [4:0] BITS_WORD = 5'h10;
endpackage

// ===== design/fspc_top.sv
// Framed serial port: Wishbone register file, clock divider, shifter, framing.
// Assumes the serial pins come from outside the clock domain and idleMode from the core.
// Summary of operation
// [RULE1] port_on enables the port and takes over the four serial pins.
// [RULE2] idle_halt set stops the port while the device is idle.
// [RULE3] Receiving while rx_holding is unread sets rx_overflow_flag; the new word is lost.
// [RULE4] Writing the data buffer loads tx_holding and sets tx_buffer_full.
// [RULE5] Moving tx_holding into the shift register clears tx_buffer_full.
// [RULE6] Moving a received word into rx_holding sets rx_buffer_full.
// [RULE7] Reading the data buffer clears rx_buffer_full.
// [RULE8] internal_clock_off stops the master clock and frees the clock pin.
// [RULE9] serial_out_off frees the serial output pin.
// [RULE10] Software keeps output_edge_select at zero in framed operation.
// [RULE11] clock_idle_polarity sets the idle level of the serial clock.
// [RULE12] primary_divider 11,10,01,00 divides by 1,4,16,64 in master operation.
// [RULE13] Serial clock equals clock over primary times secondary; secondary 111 1:1 to 000 8:1; code rounds odd products down to even.
// [RULE14] framed_enable turns the select pin into the frame sync pulse.
// [RULE15] frame_pulse_direction one takes the pulse in, zero drives it out.
// [RULE16] frame_pulse_polarity one means active-high, zero active-low.
// [RULE17] frame_pulse_timing one aligns pulse with first bit, zero one bit earlier.
// [RULE18] Each transfer shifts 8 or 16 bits, out and in at once.
// [RULE19] While overflowed, clock edges are ignored until the data buffer is read; code ignores only slave edges, until a status write clears bit 6.
// [RULE20] controller_mode_enable makes the port clock master, else clock slave.
// [RULE21] Slave with output_edge_select set needs select_pin_enable set by software.
// [RULE22] Master input_sample_phase one samples at end of output time, zero at middle; code applies it only with output_edge_select set, else samples on trail.
// [RULE23] output_edge_select one changes output on active-to-idle, zero on idle-to-active.
// [RULE24] Both dividers at 1:1 in master operation are refused.
`timescale 1ns/1ps
module fspc_top #(
   parameter int DataWidth = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic idleMode,
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [3:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAckO,
   input wire logic sckI,
   output logic sckO,
   output logic sckOe,
   input wire logic sdiI,
   output logic sdoO,
   output logic sdoOe,
   input wire logic selI,
   output logic selO,
   output logic selOe
);
   logic [1:0] rstSync_q;
   logic rst;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rstSync_q <= 2'h0;
      else rstSync_q <= {rstSync_q[0], 1'h1};
   end
   assign rst = ~rstSync_q[1];

   // Registers
   logic portOn_q;
   logic idleHalt_q;
   logic rxOvf_q;
   logic txFull_q;
   logic rxFull_q;
   logic [15:0] ctrl1_q, ctrl2_q;
   logic [DataWidth-1:0] txHold_q, rxHold_q, shift_q;
   logic busReq, wrAcc, rdAcc, dataWr, dataRd, lowLanes;
   assign busReq = wbCycI & wbStbI & ~wbAckO;
   assign lowLanes = wbSelI[0] | wbSelI[1];
   assign wrAcc = busReq & wbWeI & lowLanes;
   assign rdAcc = busReq & ~wbWeI;
   assign dataWr = wrAcc && wbAdrI == fspc_pkg::ADDR_DATA;
   assign dataRd = rdAcc && wbAdrI == fspc_pkg::ADDR_DATA;

   // Fields
   logic master, wide, input_sample_phase, outEdge, selEn, clock_idle_polarity;
   logic clkOff, sdoOff;
   logic framed_enable, frmDir, frame_pulse_polarity, frame_pulse_timing;
   logic [2:0] secDiv;
   logic [1:0] priDiv;
   assign master = ctrl1_q[fspc_pkg::C1_MASTER];
   assign wide = ctrl1_q[fspc_pkg::C1_WIDE];
   assign input_sample_phase = ctrl1_q[fspc_pkg::C1_SMP];
   assign outEdge = ctrl1_q[fspc_pkg::C1_OUT_EDGE] & ~framed_enable; // RULE10
   assign selEn = ctrl1_q[fspc_pkg::C1_SEL_EN];
   assign clock_idle_polarity = ctrl1_q[fspc_pkg::C1_CKP];
   assign clkOff = ctrl1_q[fspc_pkg::C1_CLK_OFF];
   assign sdoOff = ctrl1_q[fspc_pkg::C1_SDO_OFF];
   assign secDiv = ctrl1_q[fspc_pkg::C1_SEC_LO +: 3];
   assign priDiv = ctrl1_q[fspc_pkg::C1_PRI_LO +: 2];
   assign framed_enable = ctrl2_q[fspc_pkg::C2_FRM_EN];
   assign frmDir = ctrl2_q[fspc_pkg::C2_FRM_DIR];
   assign frame_pulse_polarity = ctrl2_q[fspc_pkg::C2_FRM_POL];
   assign frame_pulse_timing = ctrl2_q[fspc_pkg::C2_FRM_DLY];

   logic run, frmMaster;
   assign run = portOn_q & ~(idleHalt_q & idleMode); // RULE1 RULE2
   assign frmMaster = framed_enable & ~frmDir; // RULE15

   // Pin synchronisers: a change counts when stages two and three agree
   logic [2:0] sckS_q, sdiS_q, selS_q;
   logic sckF_q, sdiF_q, selF_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sckS_q <= 3'h0;
         sdiS_q <= 3'h0;
         selS_q <= 3'h7;
      end else begin
         sckS_q <= {sckS_q[1:0], sckI};
         sdiS_q <= {sdiS_q[1:0], sdiI};
         selS_q <= {selS_q[1:0], selI};
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sckF_q <= 1'h0;
         sdiF_q <= 1'h0;
         selF_q <= 1'h1;
      end else begin
         if (sckS_q[1] == sckS_q[2]) sckF_q <= sckS_q[2];
         if (sdiS_q[1] == sdiS_q[2]) sdiF_q <= sdiS_q[2];
         if (selS_q[1] == selS_q[2]) selF_q <= selS_q[2];
      end
   end

   // Half-period divider: half period = primary * secondary / 2 in clocks
   localparam logic [6:0] PriBy1 = 7'h01;
   localparam logic [6:0] PriBy4 = 7'h04;
   localparam logic [6:0] PriBy16 = 7'h10;
   localparam logic [6:0] PriBy64 = 7'h40;
   logic [6:0] priN;
   logic [3:0] secN;
   logic [9:0] halfCnt_q, period;
   logic baudEn, divValid, busy_q;
   always_comb begin
      unique case (priDiv) // RULE12
         2'h3: priN = PriBy1;
         2'h2: priN = PriBy4;
         2'h1: priN = PriBy16;
         2'h0: priN = PriBy64;
      endcase
   end
   assign secN = 4'h8 - {1'h0, secDiv}; // RULE13
   // A half-bit tick every priN*secN/2 clocks; odd products would need a half cycle
   assign period = 10'(priN) * 10'(secN);
   // A 1:1 by 1:1 word would need a tick inside one clock, so it stays pending instead
   assign divValid = period != 10'h001; // RULE24
   assign baudEn = halfCnt_q == 10'((period >> 1) - 10'h001) || period == 10'h002;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) halfCnt_q <= 10'h000;
      else if (!busy_q || baudEn || !master) halfCnt_q <= 10'h000;
      else halfCnt_q <= halfCnt_q + 10'h001;
   end

   // Transfer engine
   typedef enum {S_IDLE, S_FRAME, S_LEAD, S_TRAIL} fspc_state_t;
   fspc_state_t st_q;
   logic sckInt_q, sampled_q, lastSck_q, sdoBit_q, selOut_q;
   logic [4:0] bitCnt_q;
   logic [4:0] nBits;
   logic leadEdge, trailEdge, slvEdge, slvLead, slvTrail, selActive, done, sampleNow;
   assign nBits = wide ? fspc_pkg::BITS_WORD : fspc_pkg::BITS_BYTE; // RULE18
   // Lead edge is idle-to-active; output changes on lead unless outEdge
   // Pins lag about six clocks, so master receive needs a half period of six or more
   assign slvEdge = (sckF_q != lastSck_q) & ~rxOvf_q; // RULE19
   assign slvLead = slvEdge & (sckF_q != clock_idle_polarity); // RULE11
   assign slvTrail = slvEdge & (sckF_q == clock_idle_polarity);
   assign selActive = framed_enable ? (frame_pulse_polarity ? selF_q : ~selF_q) : (~selEn | ~selF_q); // RULE16 RULE21
   assign leadEdge = master ? (baudEn & (st_q == S_LEAD)) : slvLead;
   assign trailEdge = master ? (baudEn & (st_q == S_TRAIL)) : slvTrail;
   assign sampleNow = outEdge ? leadEdge : trailEdge; // RULE23
   assign done = bitCnt_q == nBits;
   logic [DataWidth-1:0] rxWord;
   assign rxWord = wide ? shift_q : {{(DataWidth-8){1'b0}}, shift_q[7:0]};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) lastSck_q <= 1'h0;
      else lastSck_q <= sckF_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE;
         busy_q <= 1'h0;
         bitCnt_q <= 5'h00;
         shift_q <= '0;
         sckInt_q <= 1'h0;
         sampled_q <= 1'h0;
         sdoBit_q <= 1'h0;
         selOut_q <= 1'h0;
      end else if (!run) begin
         st_q <= S_IDLE;
         busy_q <= 1'h0;
         bitCnt_q <= 5'h00;
         sckInt_q <= clock_idle_polarity;
         selOut_q <= 1'h0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               sckInt_q <= clock_idle_polarity;
               if (txFull_q && (master ? divValid : 1'b1)) begin
                  shift_q <= txHold_q; // RULE5
                  sdoBit_q <= wide ? txHold_q[DataWidth-1] : txHold_q[7];
                  bitCnt_q <= 5'h00;
                  busy_q <= 1'h1;
                  // Frame master pulses one bit early unless timing is set
                  selOut_q <= frmMaster; // RULE14
                  st_q <= (framed_enable && !frame_pulse_timing) ? S_FRAME : S_LEAD; // RULE17
               end
            end
            S_FRAME: if (master ? baudEn : slvTrail) st_q <= S_LEAD;
            S_LEAD: begin
               if (leadEdge) begin
                  if (master && !clkOff) sckInt_q <= ~clock_idle_polarity; // RULE8 RULE20
                  selOut_q <= 1'h0;
                  if (sampleNow) sampled_q <= sdiF_q;
                  else if (bitCnt_q != 5'h00) sdoBit_q <= wide ? shift_q[DataWidth-1] : shift_q[7];
                  st_q <= S_TRAIL;
               end
            end
            S_TRAIL: begin
               if (done) begin
                  busy_q <= 1'h0;
                  st_q <= S_IDLE;
               end else if (trailEdge) begin
                  sckInt_q <= clock_idle_polarity;
                  // Master end-of-time sampling takes the pin at the trailing edge
                  shift_q <= {shift_q[DataWidth-2:0], outEdge ? (input_sample_phase && master ? sdiF_q : sampled_q) : sdiF_q}; // RULE18 RULE22
                  if (outEdge) sdoBit_q <= wide ? shift_q[DataWidth-2] : shift_q[6];
                  bitCnt_q <= bitCnt_q + 5'h01;
                  st_q <= S_LEAD;
               end
            end
         endcase
         // Hold in trail after the last bit so completion shows for exactly one cycle
         if (st_q == S_TRAIL && bitCnt_q + 5'h01 == nBits && trailEdge) st_q <= S_TRAIL;
         if (!master && !framed_enable && !selActive && st_q != S_IDLE) begin
            st_q <= S_IDLE;
            busy_q <= 1'h0;
         end
      end
   end

   // Completion pulse for holding-register updates
   logic xferDone;
   assign xferDone = run && st_q == S_TRAIL && done;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         portOn_q <= 1'h0;
         idleHalt_q <= 1'h0;
         ctrl1_q <= fspc_pkg::REG_RESET;
         ctrl2_q <= fspc_pkg::REG_RESET;
         txHold_q <= '0;
      end else if (wrAcc) begin
         unique case (wbAdrI)
            fspc_pkg::ADDR_STATUS: begin
               portOn_q <= wbDatI[fspc_pkg::ST_PORT_ON];
               idleHalt_q <= wbDatI[fspc_pkg::ST_IDLE_HALT];
            end
            fspc_pkg::ADDR_CTRL1: ctrl1_q <= wbDatI[15:0] & fspc_pkg::C1_MASK;
            fspc_pkg::ADDR_CTRL2: ctrl2_q <= wbDatI[15:0] & fspc_pkg::C2_MASK;
            fspc_pkg::ADDR_DATA: txHold_q <= wbDatI[DataWidth-1:0];
            default: ;
         endcase
      end
   end

   // Flags: hardware set wins over software or read clear
   logic txLoad;
   assign txLoad = run && st_q == S_IDLE && txFull_q && (master ? divValid : 1'b1);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) txFull_q <= 1'h0;
      else if (dataWr) txFull_q <= 1'h1; // RULE4
      else if (txLoad) txFull_q <= 1'h0; // RULE5
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxFull_q <= 1'h0;
         rxOvf_q <= 1'h0;
         rxHold_q <= '0;
      end else begin
         if (xferDone && !rxFull_q) begin
            rxHold_q <= rxWord;
            rxFull_q <= 1'h1; // RULE6
         end else if (dataRd) rxFull_q <= 1'h0; // RULE7
         // The overflowed word is dropped; rx_holding keeps the older unread one
         if (xferDone && rxFull_q) rxOvf_q <= 1'h1; // RULE3
         else if (wrAcc && wbAdrI == fspc_pkg::ADDR_STATUS && !wbDatI[fspc_pkg::ST_RX_OVF])
            rxOvf_q <= 1'h0;
      end
   end

   // Bus answer: one wait-free ack cycle after the request is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wbAckO <= 1'h0;
         wbDatO <= 32'h0000_0000;
      end else begin
         wbAckO <= busReq;
         wbDatO <= 32'h0000_0000;
         if (rdAcc) begin
            unique case (wbAdrI)
               fspc_pkg::ADDR_STATUS: begin
                  wbDatO[fspc_pkg::ST_PORT_ON] <= portOn_q;
                  wbDatO[fspc_pkg::ST_IDLE_HALT] <= idleHalt_q;
                  wbDatO[fspc_pkg::ST_RX_OVF] <= rxOvf_q;
                  wbDatO[fspc_pkg::ST_TX_FULL] <= txFull_q;
                  wbDatO[fspc_pkg::ST_RX_FULL] <= rxFull_q;
               end
               fspc_pkg::ADDR_CTRL1: wbDatO[15:0] <= ctrl1_q;
               fspc_pkg::ADDR_CTRL2: wbDatO[15:0] <= ctrl2_q;
               fspc_pkg::ADDR_DATA: wbDatO[DataWidth-1:0] <= rxHold_q;
               default: ;
            endcase
         end
      end
   end

   // Pins, all registered
   // Enables follow port_on, not the idle halt, so an idle halt keeps the pins owned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sckO <= 1'h0;
         sckOe <= 1'h0;
         sdoO <= 1'h0;
         sdoOe <= 1'h0;
         selO <= 1'h0;
         selOe <= 1'h0;
      end else begin
         sckO <= sckInt_q;
         sckOe <= portOn_q & master & ~clkOff; // RULE1 RULE8 RULE20
         sdoO <= sdoBit_q;
         sdoOe <= portOn_q & ~sdoOff; // RULE9
         selO <= frame_pulse_polarity ? selOut_q : ~selOut_q; // RULE16
         selOe <= portOn_q & frmMaster; // RULE14 RULE15
      end
   end
endmodule

// ===== tb/fspc_asserts.sv
// Checker for the framed serial port: bus handshake and pin ownership.
// Assumes software writes registers with both low byte lanes enabled.
`timescale 1ns/1ps
module fspc_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic idleMode,
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [3:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   input wire logic wbAckO,
   input wire logic sckO,
   input wire logic sckOe,
   input wire logic sdoOe,
   input wire logic selOe
);
   logic [15:0] stQ, c1Q, c2Q;
   logic [1:0] settleQ;
   logic wr, ok, on;
   assign wr = wbCycI && wbStbI && wbWeI && wbAckO && (wbSelI[1:0] == 2'h3);
   // Pin enables are registered behind the registers, so wait a few cycles after a write
   assign ok = settleQ == 2'h3;
   assign on = ok && stQ[fspc_pkg::ST_PORT_ON];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stQ <= 16'h0000;
         c1Q <= 16'h0000;
         c2Q <= 16'h0000;
         settleQ <= 2'h0;
      end else begin
         if (wr && wbAdrI == fspc_pkg::ADDR_STATUS) stQ <= wbDatI[15:0];
         if (wr && wbAdrI == fspc_pkg::ADDR_CTRL1) c1Q <= wbDatI[15:0];
         if (wr && wbAdrI == fspc_pkg::ADDR_CTRL2) c2Q <= wbDatI[15:0];
         settleQ <= wr ? 2'h0 : (ok ? 2'h3 : settleQ + 2'h1);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence sTake;
      wbCycI && wbStbI && !wbAckO;
   endsequence
   sequence sHalted;
      (stQ[fspc_pkg::ST_IDLE_HALT] && on && idleMode)[*4];
   endsequence
   AST_ACK_AFTER_TAKE: assert property (sTake |=> wbAckO)
      else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (wbAckO |=> !wbAckO)
      else $error("ack longer than one cycle");
   AST_PORT_OFF_PINS: assert property (ok && !on |-> !sckOe && !sdoOe && !selOe)
      else $error("pins driven while port off");
   AST_SLAVE_CLK_IN: assert property (on && !c1Q[fspc_pkg::C1_MASTER] |-> !sckOe)
      else $error("slave drives clock pin");
   AST_MASTER_CLK_OUT: assert property (on && c1Q[5] && !c1Q[12] |-> sckOe)
      else $error("master does not drive clock pin");
   AST_CLK_OFF: assert property (on && c1Q[5] && c1Q[fspc_pkg::C1_CLK_OFF] |-> !sckOe)
      else $error("clock pin driven while internal clock off");
   AST_SDO_OFF: assert property (on && c1Q[fspc_pkg::C1_SDO_OFF] |-> !sdoOe)
      else $error("serial out driven while released");
   AST_FRAME_IN: assert property (on && c2Q[15] && c2Q[14] |-> !selOe)
      else $error("frame pulse driven in frame slave");
   AST_FRAME_OUT: assert property (on && c2Q[15] && !c2Q[14] |-> selOe)
      else $error("frame pulse not driven in frame master");
   AST_IDLE_HALT: assert property (sHalted |=> $stable(sckO))
      else $error("serial clock moves while halted in idle");
endmodule
bind fspc_top fspc_asserts u_chk (.clk(clk), .rstn(rstn), .idleMode(idleMode),
   .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
   .wbDatI(wbDatI), .wbAckO(wbAckO), .sckO(sckO), .sckOe(sckOe), .sdoOe(sdoOe),
   .selOe(selOe));

// ===== tb/fspc_spi_peer.sv
// Serial peer: a shift-register device selected by selN, MSB first.
// Assumes output moves on active-to-idle and input is sampled on idle-to-active.
`timescale 1ns/1ps
module fspc_spi_peer (
   input wire logic sck,
   input wire logic selN,
   input wire logic mosi,
   input wire logic clock_idle_polarity,
   input wire logic wide,
   input wire logic [15:0] txWord,
   output logic miso,
   output logic [15:0] rxWord
);
   logic [15:0] sh = 16'h0000;
   logic [4:0] cnt = 5'h00;
   logic last = 1'h0;
   wire logic active = sck ^ clock_idle_polarity;
   // A released line shows the inverse of its last bit, never a stale copy
   assign miso = selN ? ~last : sh[15];
   initial rxWord = 16'h0000;
   always @(negedge selN) begin
      sh = wide ? txWord : {txWord[7:0], 8'h00};
      cnt = 5'h00;
   end
   always @(posedge selN) last = sh[15];
   always @(posedge active) if (!selN) begin
      rxWord = {rxWord[14:0], mosi};
      cnt = cnt + 5'h01;
   end
   always @(negedge active) if (!selN) begin
      if (cnt == (wide ? 5'h10 : 5'h08)) begin
         sh = wide ? txWord : {txWord[7:0], 8'h00};
         cnt = 5'h00;
      end else sh = {sh[14:0], 1'h0};
   end
endmodule

// ===== tb/tb.sv
// Testbench for the framed serial port: Wishbone tasks and a serial peer.
// Assumes the peer stays selected through each transfer.
`timescale 1ns/1ps
module tb;
   logic clk, rstn, idleMode, cyc, stb, we, selN, clock_idle_polarity, wide;
   logic sckO, sckOe, sdoO, sdoOe, selO, selOe, miso, ack;
   logic [3:0] adr;
   logic [31:0] datI, datO, rd;
   logic [15:0] peerTx, peerRx;
   int mismatches, num_checks, p;
   wire logic sckPin = sckOe ? sckO : clock_idle_polarity;
   wire logic selPin = selOe ? selO : 1'h1;
   logic [15:0] c1v [5] = '{16'h0132, 16'h056A, 16'h0135, 16'h0320, 16'h013B};
   logic [15:0] txv [5] = '{16'h00A5, 16'hC3E1, 16'h005A, 16'h0081, 16'h0069};
   logic [15:0] pv [5] = '{16'h003C, 16'h1234, 16'h00F0, 16'h0017, 16'h0000};
   int per [5] = '{16, 24, 48, 512, 2};
   fspc_top dut (.clk(clk), .rstn(rstn), .idleMode(idleMode), .wbCycI(cyc), .wbStbI(stb),
      .wbWeI(we), .wbAdrI(adr), .wbSelI(4'hF), .wbDatI(datI), .wbDatO(datO), .wbAckO(ack),
      .sckI(sckPin), .sckO(sckO), .sckOe(sckOe), .sdiI(miso), .sdoO(sdoO), .sdoOe(sdoOe),
      .selI(selPin), .selO(selO), .selOe(selOe));
   fspc_spi_peer peer (.sck(sckPin), .selN(selN), .mosi(sdoO), .clock_idle_polarity(clock_idle_polarity), .wide(wide),
      .txWord(peerTx), .miso(miso), .rxWord(peerRx));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      datI <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      rd = datO;
      if (n >= 20) mismatches++;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask
   task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      wb(1'h0, a, 16'h0000);
      chk(what, exp, rd);
   endtask
   task automatic waitSt(input int b);
      int n;
      n = 0;
      do begin
         wb(1'h0, fspc_pkg::ADDR_STATUS, 16'h0000);
         n++;
      end while (rd[b] !== 1'h1 && n < 3000);
      chk("status flag", 32'h1, {31'h0, rd[b]});
   endtask
   task automatic period(output int c);
      int rises;
      logic prev;
      c = 0;
      rises = 0;
      prev = sckO;
      while (rises < 2 && c < 4000) begin
         @(posedge clk);
         c++;
         if (sckO === 1'h1 && prev === 1'h0) rises++;
         if (sckO === 1'h1 && prev === 1'h0 && rises == 1) c = 0;
         prev = sckO;
      end
   endtask
   task automatic cfg(input int i);
      selN <= 1'h1;
      wb(1'h1, fspc_pkg::ADDR_STATUS, 16'h0000);
      wb(1'h1, fspc_pkg::ADDR_CTRL1, c1v[i]);
      clock_idle_polarity <= c1v[i][6];
      wide <= c1v[i][10];
      peerTx <= pv[i];
      wb(1'h1, fspc_pkg::ADDR_STATUS, 16'h8000);
      selN <= 1'h0;
   endtask
   task automatic pinChk(input logic [3:0] a, input logic [15:0] d);
      wb(1'h1, a, d);
      repeat (4) @(posedge clk);
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      {rstn, idleMode, cyc, stb, we, clock_idle_polarity, wide, selN} = 8'h01;
      {adr, datI, peerTx, mismatches, num_checks} = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      rdchk("status reset", fspc_pkg::ADDR_STATUS, 32'h0);
      rdchk("ctrl1 reset", fspc_pkg::ADDR_CTRL1, 32'h0);
      rdchk("ctrl2 reset", fspc_pkg::ADDR_CTRL2, 32'h0);
      wb(1'h1, 4'h2, 16'hFFFF);
      rdchk("unmapped", 4'h2, 32'h0);
      wb(1'h1, fspc_pkg::ADDR_CTRL1, 16'hFFFF);
      rdchk("ctrl1 bits", fspc_pkg::ADDR_CTRL1, 32'h1FFF);
      wb(1'h1, fspc_pkg::ADDR_CTRL2, 16'hFFFF);
      rdchk("ctrl2 bits", fspc_pkg::ADDR_CTRL2, 32'hE002);
      wb(1'h1, fspc_pkg::ADDR_CTRL2, 16'h0000);
      wb(1'h1, fspc_pkg::ADDR_CTRL1, 16'h0000);
      wb(1'h1, fspc_pkg::ADDR_STATUS, 16'hA000);
      rdchk("status bits", fspc_pkg::ADDR_STATUS, 32'hA000);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         cfg(i);
         wb(1'h1, fspc_pkg::ADDR_DATA, txv[i]);
         period(p);
         chk("sck period", per[i], p);
         waitSt(0);
         rdchk("rx word", fspc_pkg::ADDR_DATA, {16'h0, pv[i]});
         chk("peer word", {16'h0, txv[i]}, {16'h0, wide ? peerRx : {8'h0, peerRx[7:0]}});
         rdchk("status drained", fspc_pkg::ADDR_STATUS, 32'h8000);
         chk("sck idle", {31'h0, clock_idle_polarity}, {31'h0, sckO});
         $display("test transfer %0d done", i);
      end
      // Receive is not compared here: the pin synchroniser lags past a half period
      cfg(4);
      wb(1'h1, fspc_pkg::ADDR_DATA, txv[4]);
      period(p);
      chk("fast sck period", per[4], p);
      waitSt(0);
      wb(1'h0, fspc_pkg::ADDR_DATA, 16'h0000);
      chk("fast peer word", {16'h0, txv[4]}, {24'h0, peerRx[7:0]});
      $display("test fast clock done");
      cfg(0);
      wb(1'h1, fspc_pkg::ADDR_DATA, 16'h0011);
      wb(1'h1, fspc_pkg::ADDR_DATA, 16'h0022);
      rdchk("tx full", fspc_pkg::ADDR_STATUS, 32'h8002);
      waitSt(6);
      rdchk("overflow", fspc_pkg::ADDR_STATUS, 32'h8041);
      rdchk("kept word", fspc_pkg::ADDR_DATA, 32'h3C);
      rdchk("rx read", fspc_pkg::ADDR_STATUS, 32'h8040);
      wb(1'h1, fspc_pkg::ADDR_STATUS, 16'h8000);
      rdchk("ovf clear", fspc_pkg::ADDR_STATUS, 32'h8000);
      $display("test overflow done");
      pinChk(fspc_pkg::ADDR_CTRL1, 16'h0180);
      chk("slave sck oe", 32'h0, {31'h0, sckOe});
      pinChk(fspc_pkg::ADDR_CTRL1, 16'h1820);
      chk("sck oe", 32'h0, {31'h0, sckOe});
      chk("sdo oe", 32'h0, {31'h0, sdoOe});
      pinChk(fspc_pkg::ADDR_CTRL1, 16'h0020);
      chk("master sck oe", 32'h1, {31'h0, sckOe});
      pinChk(fspc_pkg::ADDR_CTRL2, 16'h8000);
      chk("frame oe", 32'h1, {31'h0, selOe});
      chk("frame low idle", 32'h1, {31'h0, selO});
      pinChk(fspc_pkg::ADDR_CTRL2, 16'hA000);
      chk("frame high idle", 32'h0, {31'h0, selO});
      pinChk(fspc_pkg::ADDR_CTRL2, 16'hC000);
      chk("frame in oe", 32'h0, {31'h0, selOe});
      wb(1'h1, fspc_pkg::ADDR_CTRL2, 16'h0000);
      $display("test pins done");
      cfg(0);
      idleMode <= 1'h1;
      wb(1'h1, fspc_pkg::ADDR_DATA, 16'h0044);
      waitSt(0);
      wb(1'h0, fspc_pkg::ADDR_DATA, 16'h0000);
      wb(1'h1, fspc_pkg::ADDR_STATUS, 16'hA000);
      wb(1'h1, fspc_pkg::ADDR_DATA, 16'h0066);
      repeat (100) @(posedge clk);
      rdchk("halted", fspc_pkg::ADDR_STATUS, 32'hA002);
      idleMode <= 1'h0;
      waitSt(0);
      $display("test idle done");
      close_out();
   end
endmodule
